// ==== design/xbhp_device.sv ====
`timescale 1ns/1ns
module xbhp_device (
  input wire logic mclk,
  input wire logic rstn,
  xbhp_if.device bus,
  input wire logic [3:0] baud_switch_pack_tx,
  input wire logic [3:0] baud_switch_pack_rx,
  input wire logic modem_test_mode_n,
  input wire logic modem_ready_to_rx_n,
  input wire logic modem_data_mode_n,
  input wire logic irq_event,
  input wire logic [7:0] store_byte,
  output logic [3:0] tx_rate,
  output logic [3:0] rx_rate,
  output logic [7:0] fetch_byte,
  output logic fetch_valid
);
  // ***********************************
  // rate selection
  // ***********************************
  // open switch reads high, so all-open leaves program in control
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      tx_rate <= xbhp_pkg::RATE_ALL_HIGH;
    end else begin
      tx_rate <= bus.tx_rate_eff & baud_switch_pack_tx;
    end
  end

  // own flop for receive, so a transmit change leaves it alone
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rx_rate <= xbhp_pkg::RATE_ALL_HIGH;
    end else begin
      rx_rate <= bus.rx_rate_eff & baud_switch_pack_rx;
    end
  end

  // ***********************************
  // registers
  // ***********************************
  logic [7:0] regs_reg [xbhp_pkg::NREG];
  logic done_reg;
  logic wr_hit, rd_hit;
  logic [1:0] idx;
  xbhp_pkg::xbhp_dma_state_t state_reg;

  assign idx = bus.addr_bus[xbhp_pkg::REG_IDX_W-1:0];
  assign wr_hit = !bus.select_n && !bus.wr_enable_n && state_reg == xbhp_pkg::XBHP_IDLE;
  assign rd_hit = !bus.select_n && !bus.rd_enable_n;
  // reply follows the strobes with no clock, so a slow host sees it at once
  logic strobed;
  always_comb begin
    strobed = !bus.rd_enable_n || !bus.wr_enable_n;
    bus.reply_n = !(!bus.select_n && strobed);
  end

  // master clear spares the two keep bits of control
  // clear is sampled on the rising clock edge, so a glitch that misses every edge is ignored
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < xbhp_pkg::NREG; i++) begin
        regs_reg[i] <= xbhp_pkg::REG_RESET;
      end
    end else if (!bus.master_clear_n) begin
      for (int i = 0; i < xbhp_pkg::NREG; i++) begin
        regs_reg[i] <= xbhp_pkg::REG_RESET;
      end
      regs_reg[xbhp_pkg::REG_CTRL] <=
        regs_reg[xbhp_pkg::REG_CTRL] & xbhp_pkg::CTRL_KEEP_MASK;
    end else begin
      if (wr_hit) begin
        regs_reg[idx] <= bus.data_bus;
      end
      if (state_reg == xbhp_pkg::XBHP_DONE) begin
        regs_reg[xbhp_pkg::REG_CTRL][xbhp_pkg::CTRL_FETCH_BIT] <= 1'b0;
        regs_reg[xbhp_pkg::REG_CTRL][xbhp_pkg::CTRL_STORE_BIT] <= 1'b0;
      end
    end
  end

  logic done_set, done_clr;
  assign done_set = state_reg == xbhp_pkg::XBHP_DONE || irq_event;
  // write-one-to-clear on the status byte
  assign done_clr = wr_hit && idx == xbhp_pkg::REG_STAT &&
                    bus.data_bus[xbhp_pkg::STAT_DONE_BIT];

  // done flag: hardware set wins over a status write
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      done_reg <= 1'b0;
    end else if (!bus.master_clear_n) begin
      done_reg <= 1'b0;
    end else if (done_set) begin
      done_reg <= 1'b1;
    end else if (done_clr) begin
      done_reg <= 1'b0;
    end
  end

  assign bus.irq_n = !(done_reg &&
    regs_reg[xbhp_pkg::REG_CTRL][xbhp_pkg::CTRL_IRQ_EN_BIT]);

  // ***********************************
  // dma sequencer
  // ***********************************
  logic is_fetch_reg;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= xbhp_pkg::XBHP_IDLE;
      is_fetch_reg <= 1'b0;
    end else if (!bus.master_clear_n) begin
      state_reg <= xbhp_pkg::XBHP_IDLE;
    end else begin
      unique case (state_reg)
        xbhp_pkg::XBHP_IDLE: begin
          // fetch wins when both bits are set
          if (regs_reg[xbhp_pkg::REG_CTRL][xbhp_pkg::CTRL_FETCH_BIT]) begin
            state_reg <= xbhp_pkg::XBHP_REQ;
            is_fetch_reg <= 1'b1;
          end else if (regs_reg[xbhp_pkg::REG_CTRL][xbhp_pkg::CTRL_STORE_BIT]) begin
            state_reg <= xbhp_pkg::XBHP_REQ;
            is_fetch_reg <= 1'b0;
          end
        end
        // request held until grant, grant means host released the bus
        // no grant timeout: a host that never grants stalls the sequencer
        xbhp_pkg::XBHP_REQ: begin
          if (!bus.dma_grant_n) begin
            state_reg <= xbhp_pkg::XBHP_XFER;
          end
        end
        xbhp_pkg::XBHP_XFER: begin
          state_reg <= xbhp_pkg::XBHP_DONE;
        end
        xbhp_pkg::XBHP_DONE: begin
          state_reg <= xbhp_pkg::XBHP_IDLE;
        end
      endcase
    end
  end

  // each request line is owned by one direction only
  logic in_req;
  always_comb begin
    in_req = state_reg == xbhp_pkg::XBHP_REQ;
    bus.dma_fetch_req_n = !(in_req && is_fetch_reg);
    bus.dma_store_req_n = !(in_req && !is_fetch_reg);
  end

  // address bus driven only in the transfer cycle, then released
  assign bus.addr_d = {regs_reg[xbhp_pkg::REG_DMA_ADDR_HI],
                       regs_reg[xbhp_pkg::REG_DMA_ADDR_LO]};
  assign bus.addr_d_oe = state_reg == xbhp_pkg::XBHP_XFER;

  // ***********************************
  // read data and data bus drive
  // ***********************************
  logic [7:0] rd_data;
  logic in_xfer;
  assign in_xfer = state_reg == xbhp_pkg::XBHP_XFER;

  // status reads the live done flag, the other indices the stored bytes
  always_comb begin
    rd_data = regs_reg[idx];
    if (idx == xbhp_pkg::REG_STAT) begin
      rd_data = {7'h00, done_reg};
    end
  end

  // no register read drive during a dma cycle, the bus then belongs to memory
  always_comb begin
    bus.data_d = rd_data;
    bus.data_d_oe = rd_hit;
    if (in_xfer) begin
      bus.data_d = store_byte;
      bus.data_d_oe = !is_fetch_reg;
    end
  end

  // ***********************************
  // fetch capture
  // ***********************************
  // one-cycle strobe marks a fresh byte taken from memory
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fetch_valid <= 1'b0;
    end else begin
      fetch_valid <= in_xfer && is_fetch_reg;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fetch_byte <= xbhp_pkg::REG_RESET;
    end else if (in_xfer && is_fetch_reg) begin
      fetch_byte <= bus.data_bus;
    end
  end

  // ***********************************
  // modem status
  // ***********************************
  assign bus.test_mode_n = modem_test_mode_n;
  assign bus.ready_to_rx_n = modem_ready_to_rx_n;
  assign bus.data_mode_n = modem_data_mode_n;
endmodule

// ==== design/xbhp_pkg.sv ====
// Behaviour
// - effective rate is AND of program and switches
// - transmit and receive rates chosen independently
// - host drives four-line transmit and receive codes
// - undriven rate-select lines read as high
// - address lines shared, controller drives during dma
// - eight-bit data bus shared with dma transfers
// - host grants only after releasing the bus
// - fetch request low asks memory-to-controller byte
// - store request low asks controller-to-memory byte
// - master clear zeroes registers except two bits
// - interrupt line low while service needed
// - host pulls chip select low for access
// - chip select may be tied active
// - reply low while selected and strobed
// - modem status passed through unchanged
// - common write enable for 28-pin sockets
// - eight socket write enables in fixed order
package xbhp_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int RATE_W = 4;
  localparam int SOCK_N = 8;
  localparam int SOCK_SEL_W = 3;
  localparam int SOCK_SEL_LSB = 13;
  localparam int NREG = 4;
  localparam int REG_IDX_W = 2;

  // register indices inside the controller, low address bits
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_STAT = 2'h1;
  localparam logic [1:0] REG_DMA_ADDR_LO = 2'h2;
  localparam logic [1:0] REG_DMA_ADDR_HI = 2'h3;

  // control register fields
  localparam int CTRL_FETCH_BIT = 0;
  localparam int CTRL_STORE_BIT = 1;
  localparam int CTRL_IRQ_EN_BIT = 2;
  localparam int CTRL_KEEP_LSB = 6;
  localparam logic [7:0] CTRL_KEEP_MASK = 8'hc0;
  localparam logic [7:0] REG_RESET = 8'h00;

  // status register fields
  localparam int STAT_DONE_BIT = 0;

  localparam logic [3:0] RATE_ALL_HIGH = 4'hf;
  localparam logic [7:0] SOCK_WE_IDLE = 8'hff;

  typedef enum logic [1:0] {
    XBHP_IDLE = 2'b00,
    XBHP_REQ = 2'b01,
    XBHP_XFER = 2'b10,
    XBHP_DONE = 2'b11
  } xbhp_dma_state_t;

endpackage

// ==== design/xbhp_if.sv ====
`timescale 1ns/1ns
interface xbhp_if;
  logic [3:0] tx_baud_sel;
  logic [3:0] tx_baud_sel_oe;
  logic [3:0] rx_baud_sel;
  logic [3:0] rx_baud_sel_oe;
  logic [3:0] tx_rate_eff;
  logic [3:0] rx_rate_eff;
  logic [15:0] addr_h;
  logic addr_h_oe;
  logic [15:0] addr_d;
  logic addr_d_oe;
  logic [15:0] addr_bus;
  logic [7:0] data_h;
  logic data_h_oe;
  logic [7:0] data_d;
  logic data_d_oe;
  logic [7:0] data_bus;
  logic dma_fetch_req_n;
  logic dma_store_req_n;
  logic dma_grant_n;
  logic irq_n;
  logic select_n;
  logic rd_enable_n;
  logic wr_enable_n;
  logic reply_n;
  logic master_clear_n;
  logic test_mode_n;
  logic ready_to_rx_n;
  logic data_mode_n;
  logic mem_write_n;
  logic [7:0] socket_write_en_n;

  // pull-ups on the rate lines, resolved bus levels
  for (genvar i = 0; i < 4; i++) begin : g_pull
    assign tx_rate_eff[i] = tx_baud_sel_oe[i] ? tx_baud_sel[i] : 1'b1;
    assign rx_rate_eff[i] = rx_baud_sel_oe[i] ? rx_baud_sel[i] : 1'b1;
  end
  assign addr_bus = addr_d_oe ? addr_d : (addr_h_oe ? addr_h : 16'hffff);
  assign data_bus = data_d_oe ? data_d : (data_h_oe ? data_h : 8'hff);

  modport device (
    input tx_rate_eff, rx_rate_eff, addr_bus, data_bus, dma_grant_n, select_n,
    input rd_enable_n, wr_enable_n, master_clear_n,
    output addr_d, addr_d_oe, data_d, data_d_oe, dma_fetch_req_n, dma_store_req_n,
    output irq_n, reply_n, test_mode_n, ready_to_rx_n, data_mode_n
  );
  modport host (
    input addr_bus, data_bus, dma_fetch_req_n, dma_store_req_n, irq_n, reply_n,
    input test_mode_n, ready_to_rx_n, data_mode_n,
    output tx_baud_sel, tx_baud_sel_oe, rx_baud_sel, rx_baud_sel_oe,
    output addr_h, addr_h_oe, data_h, data_h_oe, dma_grant_n, select_n,
    output rd_enable_n, wr_enable_n, master_clear_n, mem_write_n, socket_write_en_n
  );
endinterface

// ==== design/xbhp_host.sv ====
`timescale 1ns/1ns
module xbhp_host (
  input wire logic mclk,
  input wire logic rstn,
  xbhp_if.host bus,
  input wire logic [3:0] tx_rate_code,
  input wire logic [3:0] rx_rate_code,
  input wire logic rate_drive,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic cmd_mem,
  input wire logic select_tie_pad,
  input wire logic clear_req,
  output logic cmd_ready,
  output logic [7:0] rsp_rdata,
  output logic rsp_valid,
  output logic irq_pending
);
  // ***********************************
  // rate codes and reset
  // ***********************************
  assign bus.tx_baud_sel = tx_rate_code;
  assign bus.rx_baud_sel = rx_rate_code;
  assign bus.tx_baud_sel_oe = {4{rate_drive}};
  assign bus.rx_baud_sel_oe = {4{rate_drive}};
  assign bus.master_clear_n = !clear_req;
  assign irq_pending = !bus.irq_n;

  // ***********************************
  // access and grant
  // ***********************************
  logic busy_reg, granted_reg, wr_reg, mem_reg;
  logic [15:0] addr_reg;
  logic [7:0] wdata_reg;
  logic dma_req;

  assign dma_req = !bus.dma_fetch_req_n || !bus.dma_store_req_n;
  assign cmd_ready = !busy_reg && !dma_req && !granted_reg;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      busy_reg <= 1'b0;
      wr_reg <= 1'b0;
      mem_reg <= 1'b0;
      addr_reg <= 16'h0000;
      wdata_reg <= 8'h00;
    end else if (cmd_valid && cmd_ready) begin
      busy_reg <= 1'b1;
      wr_reg <= cmd_write;
      mem_reg <= cmd_mem;
      addr_reg <= cmd_addr;
      wdata_reg <= cmd_wdata;
    end else begin
      busy_reg <= 1'b0;
    end
  end

  // grant one cycle after the host's own drivers are off
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      granted_reg <= 1'b0;
    end else begin
      granted_reg <= dma_req && !busy_reg;
    end
  end
  assign bus.dma_grant_n = !granted_reg;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
    end else begin
      rsp_valid <= busy_reg;
      if (busy_reg && !wr_reg) begin
        rsp_rdata <= bus.data_bus;
      end
    end
  end

  assign bus.addr_h = addr_reg;
  assign bus.addr_h_oe = busy_reg;
  assign bus.data_h = wdata_reg;
  assign bus.data_h_oe = busy_reg && wr_reg;
  // tie pad holds select active without decode
  assign bus.select_n = select_tie_pad ? 1'b0 : !(busy_reg && !mem_reg);
  assign bus.rd_enable_n = !(busy_reg && !wr_reg && !mem_reg);
  assign bus.wr_enable_n = !(busy_reg && wr_reg && !mem_reg);
  assign bus.mem_write_n = !(busy_reg && wr_reg && mem_reg);

  // socket chosen by top address bits, fixed order
  for (genvar s = 0; s < xbhp_pkg::SOCK_N; s++) begin : g_sock
    assign bus.socket_write_en_n[s] = !(busy_reg && wr_reg && mem_reg &&
      addr_reg[xbhp_pkg::ADDR_W-1:xbhp_pkg::SOCK_SEL_LSB] ==
      (xbhp_pkg::SOCK_SEL_W)'(s));
  end
endmodule

// ==== testbench/xbhp_chk.sv ====
`timescale 1ns/1ns
// ********
// bus checks
// ********
module xbhp_chk (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [15:0] addr_bus,
  input wire logic addr_h_oe,
  input wire logic data_h_oe,
  input wire logic addr_d_oe,
  input wire logic dma_fetch_req_n,
  input wire logic dma_store_req_n,
  input wire logic dma_grant_n,
  input wire logic select_n,
  input wire logic rd_enable_n,
  input wire logic wr_enable_n,
  input wire logic reply_n,
  input wire logic master_clear_n,
  input wire logic irq_n,
  input wire logic [7:0] socket_write_en_n,
  input wire logic [3:0] tx_baud_sel_oe,
  input wire logic [3:0] tx_rate_eff
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  sequence s_fetch_wait;
    !dma_fetch_req_n && dma_grant_n;
  endsequence
  sequence s_store_wait;
    !dma_store_req_n && dma_grant_n;
  endsequence
  a_reply_strobe: assert property (
    reply_n == !(!select_n && !(rd_enable_n && wr_enable_n))) else $error("reply wrong");
  a_fetch_hold: assert property (s_fetch_wait |=> !dma_fetch_req_n)
    else $error("fetch request dropped early");
  a_store_hold: assert property (s_store_wait |=> !dma_store_req_n)
    else $error("store request dropped early");
  a_fetch_granted: assert property (
    $fell(dma_fetch_req_n) |-> s_fetch_wait ##[1:8] !dma_grant_n) else $error("no grant");
  a_grant_cause: assert property (
    $fell(dma_grant_n) |-> !($past(dma_fetch_req_n) && $past(dma_store_req_n)))
    else $error("grant without request");
  a_host_off: assert property (!dma_grant_n |-> !addr_h_oe && !data_h_oe)
    else $error("host drives bus during grant");
  a_dma_addr: assert property (
    $rose(addr_d_oe) |-> !dma_grant_n || !$past(dma_grant_n)) else $error("ungranted drive");
  a_bus_release: assert property ($rose(addr_d_oe) |-> ##[1:4] !addr_d_oe)
    else $error("address bus kept");
  a_rate_pull: assert property ((tx_rate_eff | tx_baud_sel_oe) == 4'hf)
    else $error("floating rate line low");
  a_clear_regs: assert property (
    !master_clear_n |-> ##2 irq_n && dma_fetch_req_n && dma_store_req_n)
    else $error("master clear left state");
  a_socket_one: assert property (
    socket_write_en_n != 8'hff |-> socket_write_en_n == ~(8'h01 << addr_bus[15:13]))
    else $error("wrong socket enable");
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
// ********
// bench
// ********
module tb_top;
  typedef struct packed {
    logic [3:0] tc, rc, st, sr;
    logic dr;
    logic [2:0] md;
    logic [3:0] et, er;
  } xbhp_row_t;
  xbhp_row_t rows [6] = '{'{4'hf, 4'hf, 4'hf, 4'hf, 1'b1, 3'h7, 4'hf, 4'hf},
    '{4'h3, 4'hc, 4'hf, 4'hf, 1'b1, 3'h5, 4'h3, 4'hc},
    '{4'hf, 4'hf, 4'h5, 4'ha, 1'b1, 3'h2, 4'h5, 4'ha},
    '{4'h6, 4'h9, 4'hc, 4'h3, 1'b1, 3'h0, 4'h4, 4'h1},
    '{4'h0, 4'h0, 4'hf, 4'hf, 1'b0, 3'h6, 4'hf, 4'hf},
    '{4'ha, 4'hf, 4'hf, 4'hf, 1'b1, 3'h1, 4'ha, 4'hf}};
  logic mclk, rstn, rate_drive, irq_event, fetch_valid, cmd_ready, rsp_valid, irq_pending;
  logic modem_test_mode_n, modem_ready_to_rx_n, modem_data_mode_n;
  logic cmd_valid, cmd_write, cmd_mem, select_tie_pad, clear_req;
  logic [3:0] baud_switch_pack_tx, baud_switch_pack_rx, tx_rate_code, rx_rate_code;
  logic [3:0] tx_rate, rx_rate;
  logic [7:0] store_byte, fetch_byte, cmd_wdata, rsp_rdata, q, dma_data, fetch_cap, sock_cap;
  logic [15:0] cmd_addr, dma_addr;
  logic mem_we_cap;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;
  xbhp_if link ();
  xbhp_device xbhp_device_i (.mclk, .rstn, .bus(link.device), .baud_switch_pack_tx,
    .baud_switch_pack_rx, .modem_test_mode_n, .modem_ready_to_rx_n, .modem_data_mode_n,
    .irq_event, .store_byte, .tx_rate, .rx_rate, .fetch_byte, .fetch_valid);
  xbhp_host xbhp_host_i (.mclk, .rstn, .bus(link.host), .tx_rate_code, .rx_rate_code,
    .rate_drive, .cmd_valid, .cmd_write, .cmd_addr, .cmd_wdata, .cmd_mem, .select_tie_pad,
    .clear_req, .cmd_ready, .rsp_rdata, .rsp_valid, .irq_pending);
  xbhp_chk xbhp_chk_i (.mclk, .rstn, .addr_bus(link.addr_bus), .addr_h_oe(link.addr_h_oe),
    .data_h_oe(link.data_h_oe), .addr_d_oe(link.addr_d_oe),
    .dma_fetch_req_n(link.dma_fetch_req_n), .dma_store_req_n(link.dma_store_req_n),
    .dma_grant_n(link.dma_grant_n), .select_n(link.select_n),
    .rd_enable_n(link.rd_enable_n), .wr_enable_n(link.wr_enable_n), .reply_n(link.reply_n),
    .master_clear_n(link.master_clear_n), .irq_n(link.irq_n),
    .socket_write_en_n(link.socket_write_en_n), .tx_baud_sel_oe(link.tx_baud_sel_oe),
    .tx_rate_eff(link.tx_rate_eff));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // snapshots of dma and socket activity, judged later by the tests
  always @(posedge mclk) begin
    if (link.addr_d_oe === 1'b1) dma_addr <= link.addr_bus;
    if (link.data_d_oe === 1'b1) dma_data <= link.data_bus;
    if (fetch_valid === 1'b1) fetch_cap <= fetch_byte;
    if (link.socket_write_en_n !== 8'hff) begin
      sock_cap <= link.socket_write_en_n;
      mem_we_cap <= link.mem_write_n;
    end
  end
  task conclude;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      conclude;
    end
  end
  task automatic cmd(input logic w, input logic m, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(negedge mclk);
    {cmd_valid, cmd_write, cmd_mem, cmd_addr, cmd_wdata} = {1'b1, w, m, a, d};
    while (cmd_ready !== 1'b1 && n < 50) begin
      @(negedge mclk);
      n++;
    end
    @(negedge mclk);
    cmd_valid = 1'b0;
    // writes may answer too; a missing answer only ends the wait
    for (n = 0; n < 20 && rsp_valid !== 1'b1; n++) @(posedge mclk) #1;
    q = rsp_rdata;
  endtask
  initial begin
    {rstn, rate_drive, irq_event, cmd_valid, cmd_write, cmd_mem, select_tie_pad} = 7'h00;
    {modem_test_mode_n, modem_ready_to_rx_n, modem_data_mode_n, clear_req} = 4'he;
    {baud_switch_pack_tx, baud_switch_pack_rx, tx_rate_code, rx_rate_code} = 16'hffff;
    {store_byte, cmd_wdata, cmd_addr} = {8'h5a, 8'h00, 16'h0000};
    repeat (12) @(posedge mclk);
    #1 `CHK(link.dma_fetch_req_n, 1'b1)
    `CHK(irq_pending, 1'b0)
    @(negedge mclk) rstn = 1'b1;
    foreach (rows[i]) begin
      @(negedge mclk);
      {tx_rate_code, rx_rate_code, baud_switch_pack_tx, baud_switch_pack_rx} =
        {rows[i].tc, rows[i].rc, rows[i].st, rows[i].sr};
      rate_drive = rows[i].dr;
      {modem_test_mode_n, modem_ready_to_rx_n, modem_data_mode_n} = rows[i].md;
      repeat (3) @(negedge mclk);
      `CHK(tx_rate, rows[i].et)
      `CHK(rx_rate, rows[i].er)
      `CHK({link.test_mode_n, link.ready_to_rx_n, link.data_mode_n}, rows[i].md)
      $display("rate row %0d done", i);
    end
    cmd(1, 0, 16'h0002, 8'h34);
    cmd(1, 0, 16'h0003, 8'h12);
    cmd(0, 0, 16'h0002, 8'h00);
    `CHK(q, 8'h34)
    cmd(1, 0, 16'h0000, 8'h01);
    repeat (8) @(negedge mclk);
    `CHK(dma_addr, 16'h1234)
    `CHK(fetch_cap, 8'hff)
    cmd(1, 0, 16'h0000, 8'h02);
    repeat (8) @(negedge mclk);
    `CHK(dma_data, 8'h5a)
    $display("dma tests done");
    cmd(1, 0, 16'h0000, 8'h04);
    repeat (2) @(negedge mclk);
    `CHK(irq_pending, 1'b1)
    cmd(1, 0, 16'h0001, 8'h01);
    repeat (2) @(negedge mclk);
    `CHK(irq_pending, 1'b0)
    irq_event = 1'b1;
    @(negedge mclk) irq_event = 1'b0;
    repeat (2) @(negedge mclk);
    `CHK(irq_pending, 1'b1)
    cmd(1, 0, 16'h0000, 8'hc4);
    @(negedge mclk) clear_req = 1'b1;
    repeat (2) @(negedge mclk);
    clear_req = 1'b0;
    repeat (2) @(negedge mclk);
    `CHK(irq_pending, 1'b0)
    cmd(0, 0, 16'h0000, 8'h00);
    `CHK(q, 8'hc0)
    $display("irq and clear tests done");
    select_tie_pad = 1'b1;
    cmd(1, 0, 16'h0002, 8'h77);
    cmd(0, 0, 16'h0002, 8'h00);
    `CHK(q, 8'h77)
    cmd(1, 1, 16'ha000, 8'h99);
    `CHK(sock_cap, 8'hdf)
    `CHK(mem_we_cap, 1'b0)
    $display("select and socket tests done");
    conclude;
  end
endmodule
